// File: core/twu_pkg.sv
// package for the timer and watchdog register block
package twu_pkg;
   localparam logic [2:0] ADDR_CONFIG = 3'h0;
   localparam logic [2:0] ADDR_PRESCALE = 3'h1;
   localparam logic [2:0] ADDR_RELOAD = 3'h2;
   localparam logic [2:0] ADDR_CTRL = 3'h3;
   localparam logic [2:0] ADDR_WDCOUNT = 3'h4;
   localparam logic [2:0] ADDR_SERVICE = 3'h5;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] PRESCALE_RST = 8'h00;
   localparam logic [15:0] RELOAD_RST = 16'hffff;
   localparam logic [7:0] WDCOUNT_RST = 8'h0f;
   localparam logic [7:0] SERVICE_KEY = 8'h5c;
   localparam logic [15:0] LOCKED_READ = 16'h0000;
   localparam int LOCK_CFG_BIT = 0;
   localparam int LOCK_PRE_BIT = 1;
   localparam int LOCK_TMR_BIT = 2;
   localparam int LOCK_WD_BIT = 3;
   localparam int WD_CLK_SEL_BIT = 4;
   localparam int SM_EN_BIT = 5;
   localparam int CSR_RESTART_BIT = 0;
   localparam int CSR_TC_BIT = 1;
   localparam int CSR_IRQ_EN_BIT = 2;
   localparam int CSR_TOUCH_BIT = 3;
   localparam int CSR_FRZ_BIT = 4;
   localparam logic [2:0] DIV_MAX_CODE = 3'h5;
   localparam logic [4:0] DIV_CNT_RST = 5'h00;

   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } twu_bus_req_t;
endpackage : twu_pkg

// File: core/twu_regs.sv
// timer and watchdog register block with prescaler, periodic timer and watchdog
`timescale 1ns/100ps
`default_nettype none
// How it works
// [R01] locked registers ignore writes; reads return a fixed filler value
// [R02] lock bits stick once set; only reset clears them
// [R03] reset clears config, prescale and control/status bits
// [R04] config bit 0 locks the config register
// [R05] config bit 1 locks the prescale register
// [R06] config bit 2 locks reload and control/status registers
// [R07] config bit 3 locks the watchdog count register
// [R08] config bit 4 picks prescaled tick, else periodic pulse, as watchdog clock
// [R09] match enable clear: count write services, match writes ignored
// [R10] match enable set: writing 5Ch to match register services
// [R11] prescale code 0..5 divides slow clock by 1..32
// [R12] reload register resets to FFFFh
// [R13] counter reloads from reload register on underflow
// [R14] freeze stops the timer only while freeze enable is set
// [R15] count register write-only; first write starts watchdog
// [R16] each count write stores value; restarts a running countdown only while match enable is clear
// [R17] count register resets to 0Fh
// [R18] restart reloads counter on next tick, then self-clears
// [R19] counter zero gives one-tick pulse and sets terminal count
// [R20] interrupt on terminal count only when enabled
// [R21] wrong match byte while enabled raises watchdog error
// [R22] terminal count read-only, cleared by read unless freeze input is high
// [R23] touch flag high from service write until watchdog clock takes it
// [R24] running watchdog counts down, errors at zero unserviced
module twu_regs (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic slow_clock_i,
   input wire logic freeze_i,
   output logic periodic_pulse_o,
   output logic timer_irq_o,
   output logic wd_error_o,
   output logic wd_running_o
);
   twu_pkg::twu_bus_req_t req;
   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   logic [7:0] config_r;
   logic [2:0] prescale_r;
   logic [15:0] reload_r;
   logic [15:0] count_r;
   logic restart_r;
   logic tc_r;
   logic irq_en_r;
   logic frz_en_r;
   logic [7:0] wd_load_r;
   logic [7:0] wd_cnt_r;
   logic wd_err_r;
   logic touch_r;
   logic touch_reload_r;
   logic slow_d_r;
   logic [4:0] div_cnt_r;
   logic tick;
   logic pulse_r;
   logic [15:0] rdata_r;

   typedef enum logic [1:0] {TWU_WD_IDLE, TWU_WD_RUN, TWU_WD_ERR} twu_wd_state_t;
   twu_wd_state_t wd_state_r;

   // a register is writable only when its lock bit is clear
   function automatic logic twu_locked(input logic [2:0] a, input logic [7:0] cfg);
      logic l;
      l = 1'b0;
      case (a)
         twu_pkg::ADDR_CONFIG: l = cfg[twu_pkg::LOCK_CFG_BIT]; // [R04]
         twu_pkg::ADDR_PRESCALE: l = cfg[twu_pkg::LOCK_PRE_BIT]; // [R05]
         twu_pkg::ADDR_RELOAD: l = cfg[twu_pkg::LOCK_TMR_BIT]; // [R06]
         twu_pkg::ADDR_CTRL: l = cfg[twu_pkg::LOCK_TMR_BIT]; // [R06]
         twu_pkg::ADDR_WDCOUNT: l = cfg[twu_pkg::LOCK_WD_BIT]; // [R07]
         default: l = 1'b0;
      endcase
      return l;
   endfunction : twu_locked

   logic wr_ok;
   logic rd_ok;
   assign wr_ok = req.wr && !twu_locked(req.addr, config_r); // [R01]
   assign rd_ok = req.rd && !twu_locked(req.addr, config_r); // [R01]

   logic wd_count_wr;
   logic sm_wr;
   logic sm_enabled;
   assign sm_enabled = config_r[twu_pkg::SM_EN_BIT];
   assign wd_count_wr = wr_ok && req.addr == twu_pkg::ADDR_WDCOUNT;
   assign sm_wr = req.wr && req.addr == twu_pkg::ADDR_SERVICE && sm_enabled; // [R09]

   // config: lock bits are or-ed in so no write can clear them
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         config_r <= twu_pkg::CONFIG_RST; // [R03]
      end else if (wr_ok && req.addr == twu_pkg::ADDR_CONFIG) begin
         config_r <= {2'b00, req.wdata[5:4], config_r[3:0] | req.wdata[3:0]}; // [R02]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prescale_r <= twu_pkg::PRESCALE_RST[2:0]; // [R03]
      end else if (wr_ok && req.addr == twu_pkg::ADDR_PRESCALE) begin
         prescale_r <= req.wdata[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reload_r <= twu_pkg::RELOAD_RST; // [R12]
      end else if (wr_ok && req.addr == twu_pkg::ADDR_RELOAD) begin
         reload_r <= req.wdata;
      end
   end

   // prescaler: slow clock edge detect then divide by 2**code
   logic slow_rise;
   logic [4:0] div_mask;
   assign slow_rise = slow_clock_i && !slow_d_r;
   // reserved codes fall back to the largest divisor
   assign div_mask = (prescale_r > twu_pkg::DIV_MAX_CODE) ? 5'h1f :
                     5'((6'h01 << prescale_r) - 6'h01);
   assign tick = slow_rise && ((div_cnt_r & div_mask) == div_mask); // [R11]

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         // seeded from the pin so a slow clock already high at release is not taken as an edge
         slow_d_r <= slow_clock_i;
         div_cnt_r <= twu_pkg::DIV_CNT_RST;
      end else begin
         slow_d_r <= slow_clock_i;
         if (slow_rise) begin
            div_cnt_r <= 5'(div_cnt_r + 5'h01);
         end
      end
   end

   logic frozen;
   logic timer_tick;
   assign frozen = frz_en_r && freeze_i; // [R14]
   assign timer_tick = tick && !frozen;

   // periodic counter
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         count_r <= twu_pkg::RELOAD_RST;
         pulse_r <= 1'b0;
      end else if (tick) begin
         pulse_r <= 1'b0;
         if (restart_r) begin
            count_r <= reload_r; // [R18]
         end else if (timer_tick) begin
            if (count_r == 16'h0000) begin
               count_r <= reload_r; // [R13]
            end else begin
               count_r <= 16'(count_r - 16'h0001);
               pulse_r <= (count_r == 16'h0001); // [R19]
            end
         end
      end
   end

   // pulse lasts one tick period
   assign periodic_pulse_o = pulse_r;

   logic csr_wr;
   assign csr_wr = wr_ok && req.addr == twu_pkg::ADDR_CTRL;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         restart_r <= 1'b0; // [R03]
         irq_en_r <= 1'b0;
         frz_en_r <= 1'b0;
      end else begin
         if (csr_wr) begin
            irq_en_r <= req.wdata[twu_pkg::CSR_IRQ_EN_BIT];
            frz_en_r <= req.wdata[twu_pkg::CSR_FRZ_BIT];
         end
         // a new restart request beats the self clear
         if (csr_wr && req.wdata[twu_pkg::CSR_RESTART_BIT]) begin
            restart_r <= 1'b1;
         end else if (tick) begin
            restart_r <= 1'b0; // [R18]
         end
      end
   end

   logic pulse_set;
   assign pulse_set = timer_tick && !restart_r && count_r == 16'h0001;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tc_r <= 1'b0;
      end else if (pulse_set) begin
         tc_r <= 1'b1; // [R19]
      end else if (rd_ok && req.addr == twu_pkg::ADDR_CTRL && !freeze_i) begin
         tc_r <= 1'b0; // [R22]
      end
   end

   assign timer_irq_o = pulse_r && irq_en_r; // [R20]

   // watchdog clock select
   logic wd_tick;
   assign wd_tick = config_r[twu_pkg::WD_CLK_SEL_BIT] ? tick : (tick && pulse_set); // [R08]

   logic sm_good;
   logic sm_bad;
   assign sm_good = sm_wr && req.wdata[7:0] == twu_pkg::SERVICE_KEY; // [R10]
   assign sm_bad = sm_wr && req.wdata[7:0] != twu_pkg::SERVICE_KEY; // [R21]

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wd_load_r <= twu_pkg::WDCOUNT_RST; // [R17]
      end else if (wd_count_wr) begin
         wd_load_r <= req.wdata[7:0]; // [R16]
      end
   end

   // touch pending until the next watchdog clock edge takes the value
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         touch_r <= 1'b0;
      end else if (wd_count_wr || sm_wr) begin
         touch_r <= 1'b1; // [R23]
      end else if (wd_tick) begin
         touch_r <= 1'b0;
      end
   end

   // a second match write in one watchdog clock period is an error
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         touch_reload_r <= 1'b0;
      end else if (sm_good) begin
         touch_reload_r <= 1'b1;
      end else if (wd_tick) begin
         touch_reload_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wd_state_r <= TWU_WD_IDLE;
         wd_cnt_r <= twu_pkg::WDCOUNT_RST;
         wd_err_r <= 1'b0;
      end else begin
         case (wd_state_r)
            TWU_WD_IDLE: begin
               if (sm_bad) begin
                  wd_err_r <= 1'b1; // [R21]
                  wd_state_r <= TWU_WD_ERR;
               end else if (wd_count_wr) begin
                  wd_cnt_r <= req.wdata[7:0]; // [R15]
                  wd_state_r <= TWU_WD_RUN;
               end else if (sm_good) begin
                  wd_cnt_r <= wd_load_r;
                  wd_state_r <= TWU_WD_RUN;
               end
            end
            TWU_WD_RUN: begin
               if (sm_bad || (sm_good && touch_reload_r)) begin
                  wd_err_r <= 1'b1; // [R21]
                  wd_state_r <= TWU_WD_ERR;
               end else if (wd_count_wr && !sm_enabled) begin
                  wd_cnt_r <= req.wdata[7:0]; // [R16]
               end else if (sm_good) begin
                  wd_cnt_r <= wd_load_r; // [R10]
               end else if (wd_tick) begin
                  if (wd_cnt_r == 8'h00) begin
                     wd_err_r <= 1'b1; // [R24]
                     wd_state_r <= TWU_WD_ERR;
                  end else begin
                     wd_cnt_r <= 8'(wd_cnt_r - 8'h01); // [R24]
                  end
               end
            end
            TWU_WD_ERR: wd_err_r <= 1'b1;
            default: wd_state_r <= TWU_WD_IDLE;
         endcase
      end
   end

   assign wd_running_o = wd_state_r == TWU_WD_RUN;
   assign wd_error_o = wd_err_r;

   // read data, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= 16'h0000;
      end else if (req.rd) begin
         if (!rd_ok) begin
            rdata_r <= twu_pkg::LOCKED_READ; // [R01]
         end else begin
            case (req.addr)
               twu_pkg::ADDR_CONFIG: rdata_r <= {8'h00, config_r};
               twu_pkg::ADDR_PRESCALE: rdata_r <= {13'h0000, prescale_r};
               twu_pkg::ADDR_RELOAD: rdata_r <= reload_r;
               twu_pkg::ADDR_CTRL: rdata_r <= {11'h000, frz_en_r, touch_r, irq_en_r, tc_r, restart_r};
               default: rdata_r <= 16'h0000; // write-only and unmapped read zero
            endcase
         end
      end else begin
         rdata_r <= 16'h0000;
      end
   end
   assign rdata_o = rdata_r;

   a_lock_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R02]
      (config_r[3:0] & $past(config_r[3:0])) == $past(config_r[3:0])) else $error("lock bit cleared");
   a_locked_cfg_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R04]
      config_r[0] && wr_i && addr_i == twu_pkg::ADDR_CONFIG |=> $stable(config_r))
      else $error("locked config changed");
   a_locked_pre_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R05]
      config_r[1] |=> $stable(prescale_r)) else $error("locked prescale changed");
   a_locked_rel_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
      config_r[2] |=> $stable(reload_r)) else $error("locked reload changed");
   a_restart_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R18]
      restart_r && tick && !(wr_i && addr_i == twu_pkg::ADDR_CTRL) |=> !restart_r && count_r == $past(reload_r))
      else $error("restart not done");
   a_tc_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R19]
      pulse_set |=> tc_r && pulse_r) else $error("terminal count missing");
   a_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R20]
      pulse_set && irq_en_r && !csr_wr |=> timer_irq_o && pulse_r)
      else $error("irq missing on terminal count");
   a_freeze_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R14]
      frozen && !restart_r |=> $stable(count_r)) else $error("frozen timer moved");
   a_bad_key_err: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R21]
      sm_bad |=> wd_error_o) else $error("bad key no error");
   a_wd_start: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R15]
      wd_state_r == TWU_WD_IDLE && wd_count_wr |=> wd_running_o && wd_cnt_r == $past(wdata_i[7:0]))
      else $error("watchdog not started");
   c_restart: cover property (@(posedge clk_i) restart_r ##[1:100] !restart_r);
   c_tc: cover property (@(posedge clk_i) pulse_set);
   c_service: cover property (@(posedge clk_i) sm_good && wd_running_o);
   c_error: cover property (@(posedge clk_i) $rose(wd_error_o));
   c_freeze: cover property (@(posedge clk_i) frozen && tick);

   // status, watchdog and reset checks that the pins alone cannot show
   a_tc_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R22]
      rd_ok && req.addr == twu_pkg::ADDR_CTRL && !freeze_i && !pulse_set |=> !tc_r)
      else $error("terminal count not cleared by read");
   a_tc_freeze_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R22]
      tc_r && freeze_i |=> tc_r) else $error("terminal count lost in freeze");
   a_reset_values: assert property (@(posedge clk_i) // [R03]
      !rst_n_i |=> config_r == twu_pkg::CONFIG_RST && prescale_r == twu_pkg::PRESCALE_RST[2:0] && !restart_r && !tc_r)
      else $error("registers not cleared by reset");
   a_wd_count_svc: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R16]
      wd_running_o && wd_count_wr && !sm_enabled |=> wd_cnt_r == $past(wdata_i[7:0]))
      else $error("count write did not reload watchdog");
   a_match_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
      wd_running_o && sm_good && !touch_reload_r |=> wd_cnt_r == $past(wd_load_r))
      else $error("match write did not reload watchdog");
   a_wd_late_err: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R24]
      wd_running_o && wd_tick && wd_cnt_r == 8'h00 && !wd_count_wr && !sm_wr |=> wd_error_o)
      else $error("expired watchdog gave no error");
   a_err_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R24]
      wd_error_o |=> wd_error_o) else $error("watchdog error dropped");
   a_touch_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R23]
      wd_count_wr || sm_wr |=> touch_r) else $error("touch flag not raised");
   a_match_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R09]
      !sm_enabled && wr_i && addr_i == twu_pkg::ADDR_SERVICE && wd_state_r == TWU_WD_IDLE |=> !wd_running_o && !wd_error_o)
      else $error("match write acted while disabled");
   a_reload_cnt: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
      timer_tick && !restart_r && count_r == 16'h0000 |=> count_r == $past(reload_r))
      else $error("timer did not reload on underflow");
   a_locked_ctrl_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
      config_r[2] |=> $stable(irq_en_r) && $stable(frz_en_r)) else $error("locked control changed");
endmodule : twu_regs
`default_nettype wire

// File: verif/tb_twu_regs.sv
// self-checking bench for the timer and watchdog register block
`timescale 1ns/100ps
`default_nettype none
module tb_twu_regs;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic slow_clock_i = 1'b0;
   logic freeze_i = 1'b0;
   logic [15:0] rdata_o;
   logic periodic_pulse_o;
   logic timer_irq_o;
   logic wd_error_o;
   logic wd_running_o;
   logic [2:0] sdiv = 3'h0;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int c;
   logic [15:0] d;
   logic seen;
   typedef struct packed {logic [2:0] a; logic [15:0] w; logic [15:0] e;} twu_row_t;
   twu_row_t rows [5];

   twu_regs twu_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .slow_clock_i(slow_clock_i), .freeze_i(freeze_i),
      .periodic_pulse_o(periodic_pulse_o), .timer_irq_o(timer_irq_o), .wd_error_o(wd_error_o),
      .wd_running_o(wd_running_o));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // slow clock at one eighth of the bus clock keeps well inside the sampling limit
   always @(posedge clk_i) begin
      sdiv <= sdiv + 3'h1;
      slow_clock_i <= sdiv[2];
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         report_and_stop();
      end
   end

   function automatic logic [15:0] z(input logic x);
      return {15'h0000, x};
   endfunction : z

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic idle(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : idle

   task automatic wr(input logic [2:0] a, input logic [15:0] w);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= w;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      // let the write edge settle before any caller looks at the outputs
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [15:0] g);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      g = rdata_o;
   endtask : rd

   task automatic do_reset;
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
   endtask : do_reset

   // returns cycles from the call (or the last rise) up to the next rising pulse
   task automatic wait_pulse(output int n);
      n = 0;
      while (periodic_pulse_o !== 1'b0 && n < 3000) begin
         idle(1);
         n++;
      end
      while (periodic_pulse_o !== 1'b1 && n < 3000) begin
         idle(1);
         n++;
      end
      if (n >= 3000) chk("pulse wait", 16'h0000, 16'h0001);
   endtask : wait_pulse

   task automatic wait_err(input int lim);
      int n;
      n = 0;
      while (wd_error_o !== 1'b1 && n < lim) begin
         idle(1);
         n++;
      end
   endtask : wait_err

   task automatic report_and_stop;
      $display("tests_run %0d fail_count %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      rows[0] = {twu_pkg::ADDR_CTRL, 16'h0006, 16'h0004};
      rows[1] = {twu_pkg::ADDR_CONFIG, 16'h00d0, 16'h0010};
      rows[2] = {twu_pkg::ADDR_PRESCALE, 16'h0005, 16'h0005};
      rows[3] = {twu_pkg::ADDR_RELOAD, 16'h1234, 16'h1234};
      rows[4] = {twu_pkg::ADDR_RELOAD, 16'h0003, 16'h0003};
      do_reset();
      rd(twu_pkg::ADDR_CONFIG, d);
      chk("config reset", twu_pkg::CONFIG_RST, d);
      rd(twu_pkg::ADDR_PRESCALE, d);
      chk("prescale reset", twu_pkg::PRESCALE_RST, d);
      rd(twu_pkg::ADDR_RELOAD, d);
      chk("reload reset", twu_pkg::RELOAD_RST, d);
      rd(twu_pkg::ADDR_CTRL, d);
      chk("ctrl reset", 16'h0000, d);
      chk("wd idle", 16'h0000, z(wd_running_o));
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d);
         chk("table row", rows[i].e, d);
      end
      $display("test done: reset and register table");
      wr(twu_pkg::ADDR_PRESCALE, 16'h0000);
      wr(twu_pkg::ADDR_CTRL, 16'h0005);
      idle(20);
      rd(twu_pkg::ADDR_CTRL, d);
      chk("restart self clear", 16'h0000, d & 16'h0001);
      for (int k = 0; k < 3; k++) begin
         wr(twu_pkg::ADDR_PRESCALE, {13'h0000, k[2:0]});
         wait_pulse(c);
         wait_pulse(c);
         chk("pulse period", 16'(32 << k), c[15:0]);
         chk("irq enabled", 16'h0001, z(timer_irq_o));
      end
      wr(twu_pkg::ADDR_PRESCALE, 16'h0000);
      wait_pulse(c);
      rd(twu_pkg::ADDR_CTRL, d);
      chk("tc set", 16'h0002, d & 16'h0002);
      rd(twu_pkg::ADDR_CTRL, d);
      chk("tc read clear", 16'h0000, d & 16'h0002);
      freeze_i <= 1'b1;
      wait_pulse(c);
      rd(twu_pkg::ADDR_CTRL, d);
      rd(twu_pkg::ADDR_CTRL, d);
      chk("tc kept in freeze", 16'h0002, d & 16'h0002);
      wr(twu_pkg::ADDR_CTRL, 16'h0010);
      // the pulse in flight still ends at the next tick; the count is held from the freeze enable write
      idle(10);
      seen = 1'b0;
      repeat (300) begin
         idle(1);
         seen = seen | periodic_pulse_o;
      end
      chk("frozen timer", 16'h0000, z(seen));
      freeze_i <= 1'b0;
      wait_pulse(c);
      chk("irq masked", 16'h0000, z(timer_irq_o));
      $display("test done: periodic timer");
      wr(twu_pkg::ADDR_SERVICE, {8'h00, twu_pkg::SERVICE_KEY});
      chk("match ignored", 16'h0000, z(wd_running_o));
      wr(twu_pkg::ADDR_CONFIG, 16'h0010);
      wr(twu_pkg::ADDR_WDCOUNT, 16'h0005);
      chk("wd started", 16'h0001, z(wd_running_o));
      repeat (8) begin
         idle(16);
         wr(twu_pkg::ADDR_WDCOUNT, 16'h0005);
      end
      chk("serviced no err", 16'h0000, z(wd_error_o));
      wait_err(100);
      chk("late service err", 16'h0001, z(wd_error_o));
      do_reset();
      idle(1);
      chk("err cleared", 16'h0000, z(wd_error_o | wd_running_o));
      wr(twu_pkg::ADDR_RELOAD, 16'h0003);
      wr(twu_pkg::ADDR_CTRL, 16'h0001);
      wr(twu_pkg::ADDR_WDCOUNT, 16'h0002);
      idle(40);
      chk("pulse clocked wd", 16'h0000, z(wd_error_o));
      wait_err(100);
      chk("pulse clocked err", 16'h0001, z(wd_error_o));
      $display("test done: watchdog count servicing");
      do_reset();
      wr(twu_pkg::ADDR_CONFIG, 16'h0030);
      repeat (4) begin
         wr(twu_pkg::ADDR_SERVICE, {8'h00, twu_pkg::SERVICE_KEY});
         idle(24);
      end
      idle(76);
      chk("match service", 16'h0000, z(wd_error_o));
      wait_err(60);
      chk("default count err", 16'h0001, z(wd_error_o));
      do_reset();
      wr(twu_pkg::ADDR_CONFIG, 16'h0020);
      wr(twu_pkg::ADDR_SERVICE, 16'h0033);
      wait_err(4);
      chk("wrong byte err", 16'h0001, z(wd_error_o));
      $display("test done: match servicing");
      do_reset();
      wr(3'h6, 16'h00ff);
      rd(twu_pkg::ADDR_CONFIG, d);
      chk("unmapped write", 16'h0000, d);
      wr(twu_pkg::ADDR_CONFIG, 16'h000e);
      wr(twu_pkg::ADDR_CONFIG, 16'h0000);
      rd(twu_pkg::ADDR_CONFIG, d);
      chk("locks sticky", 16'h000e, d);
      wr(twu_pkg::ADDR_PRESCALE, 16'h0003);
      rd(twu_pkg::ADDR_PRESCALE, d);
      chk("prescale locked", twu_pkg::LOCKED_READ, d);
      rd(twu_pkg::ADDR_RELOAD, d);
      chk("reload locked", twu_pkg::LOCKED_READ, d);
      rd(twu_pkg::ADDR_CTRL, d);
      chk("ctrl locked", twu_pkg::LOCKED_READ, d);
      wr(twu_pkg::ADDR_WDCOUNT, 16'h0020);
      chk("count locked", 16'h0000, z(wd_running_o));
      wr(twu_pkg::ADDR_CONFIG, 16'h0001);
      rd(twu_pkg::ADDR_CONFIG, d);
      chk("config locked", twu_pkg::LOCKED_READ, d);
      do_reset();
      rd(twu_pkg::ADDR_PRESCALE, d);
      chk("unlock by reset", twu_pkg::PRESCALE_RST, d);
      wr(twu_pkg::ADDR_PRESCALE, 16'h0003);
      rd(twu_pkg::ADDR_PRESCALE, d);
      chk("prescale after unlock", 16'h0003, d);
      $display("test done: register locking");
      report_and_stop();
   end
endmodule : tb_twu_regs
`default_nettype wire
